// *** tb/host_io_model.sv ***
// host cpu model issuing single-byte io port accesses
`timescale 1ns/100ps
`default_nettype none
module host_io_model (
  input wire logic clk_sys,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_wr,
  output logic io_rd
);
  initial begin
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
  end
  // released bus shows inverted values so a stale address never matches
  task automatic access(input logic rd, input logic [15:0] addr, input logic [7:0] data);
    @(negedge clk_sys);
    io_addr = addr;
    io_wdata = data;
    io_rd = rd;
    io_wr = ~rd;
    @(negedge clk_sys);
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_addr = ~addr;
    io_wdata = ~data;
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the io port watchdog timer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import wdt_pkg::*;
  localparam int TP = 10;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata;
  logic io_wr, io_rd, cpu_reset, wdt_irq, armed;
  logic [7:0] io_rdata_i;
  logic cpu_reset_i, wdt_irq_i, armed_i;
  int n_mismatch = 0;
  int check_count = 0;
  always #5 clk_sys = ~clk_sys;
  host_io_model host (.clk_sys(clk_sys), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd));
  io_port_watchdog_timer #(.TICK_PERIOD(TP)) uut (.clk_sys(clk_sys), .resetn(resetn),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_rdata(io_rdata), .cpu_reset(cpu_reset), .wdt_irq(wdt_irq), .armed(armed));
  // second copy on the same bus: interrupt mode, zero counts as one
  io_port_watchdog_timer #(.TICK_PERIOD(TP), .USE_IRQ(1'b1), .ZERO_DISABLES(1'b0)) uut_irq (
    .clk_sys(clk_sys), .resetn(resetn),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_rdata(io_rdata_i), .cpu_reset(cpu_reset_i), .wdt_irq(wdt_irq_i), .armed(armed_i));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // any reset, irq or armed state of uut (not uut_irq) during a quiet span counts as a hit
  task automatic watch(output logic hit);
    hit = 1'b0;
    repeat (6 * TP) begin
      @(negedge clk_sys);
      hit = hit | cpu_reset | wdt_irq | armed;
    end
  endtask
  task automatic t_expire(input logic [7:0] d);
    int n;
    host.access(1'b0, WDT_PORT_ADDR, d);
    chk("armed", armed, 8'h01);
    repeat (d[5:0] * TP) @(negedge clk_sys);
    chk("early reset", cpu_reset, 8'h00);
    n = 0;
    while (cpu_reset !== 1'b1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    chk("reset rise", cpu_reset, 8'h01);
    n = 0;
    while (cpu_reset === 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk("pulse width", 8'(n), 8'(RST_PULSE_CYCLES));
    chk("disarmed", armed, 8'h00);
  endtask
  task automatic t_refresh();
    logic hit;
    host.access(1'b0, WDT_PORT_ADDR, 8'h03);
    repeat (2 * TP) @(negedge clk_sys);
    host.access(1'b0, WDT_PORT_ADDR, 8'h03);
    repeat (2 * TP + 5) @(negedge clk_sys);
    chk("still armed", armed, 8'h01);
    host.access(1'b1, WDT_PORT_ADDR, 8'h00);
    chk("read disarms", armed, 8'h00);
    chk("remaining", io_rdata, 8'h01);
    watch(hit);
    chk("no action", hit, 8'h00);
  endtask
  task automatic t_ignore();
    logic hit;
    host.access(1'b0, WDT_PORT_ADDR - 16'h0001, 8'h01);
    chk("foreign addr", armed, 8'h00);
    host.access(1'b0, WDT_PORT_ADDR, 8'h00);
    watch(hit);
    chk("ignored", hit, 8'h00);
  endtask
  task automatic t_irq();
    host.access(1'b0, WDT_PORT_ADDR, 8'h00);
    chk("zero as one", armed_i, 8'h01);
    chk("zero disables", armed, 8'h00);
    repeat (TP) @(negedge clk_sys);
    chk("irq early", wdt_irq_i, 8'h00);
    @(negedge clk_sys);
    chk("irq raised", wdt_irq_i, 8'h01);
    chk("irq mode no reset", cpu_reset_i, 8'h00);
    host.access(1'b0, WDT_PORT_ADDR, 8'h02);
    chk("irq cleared", wdt_irq_i, 8'h00);
    host.access(1'b1, WDT_PORT_ADDR, 8'h00);
    chk("irq rdata", io_rdata_i, 8'h02);
    chk("irq disarmed", armed_i, 8'h00);
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    t_expire(8'h02);
    t_expire(8'hC1);
    t_refresh();
    t_ignore();
    t_irq();
    report_and_stop();
  end
  initial begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** verilog/io_port_watchdog_timer.sv ***
// io port watchdog timer: byte port arms, refreshes and disables a seconds countdown
`timescale 1ns/100ps
`default_nettype none
module io_port_watchdog_timer
  import wdt_pkg::*;
#(
  parameter int TICK_PERIOD = TICK_CYCLES,
  parameter bit USE_IRQ = 1'b0,
  parameter bit ZERO_DISABLES = 1'b1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  output logic cpu_reset,
  output logic wdt_irq,
  output logic armed
);
  import wdt_pkg::*;

  logic hit_wr, hit_rd, tick;
  logic [5:0] count_q, count_d;
  logic armed_q, armed_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic [4:0] rst_cnt_q, rst_cnt_d;
  logic rst_q, rst_d;
  logic expire;

  function automatic logic port_hit(input logic [15:0] a);
    port_hit = (a == WDT_PORT_ADDR);
  endfunction

  assign hit_wr = io_wr && port_hit(io_addr);
  assign hit_rd = io_rd && port_hit(io_addr);
  assign expire = armed_q && tick && (count_q == INTERVAL_MIN);

  // tick phase restarts on every port write so the first second is whole
  sec_tick #(.PERIOD(TICK_PERIOD)) u_tick (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .restart(hit_wr),
    .tick(tick)
  );

  always_comb begin
    count_d = count_q;
    armed_d = armed_q;
    rdata_d = rdata_q;
    irq_d = irq_q;
    rst_cnt_d = rst_cnt_q;
    rst_d = 1'b0;
    if (hit_rd) begin
      armed_d = 1'b0;
      rdata_d = {2'b00, count_q};
    end else if (hit_wr) begin
      count_d = io_wdata[5:0];
      armed_d = 1'b1;
      // a flag raised in the same cycle as the clearing write stays up
      irq_d = expire && USE_IRQ;
      if (io_wdata[5:0] == 6'h00 && ZERO_DISABLES) begin
        armed_d = 1'b0;
      end else if (io_wdata[5:0] == 6'h00) begin
        count_d = INTERVAL_MIN;
      end
    end else if (expire) begin
      armed_d = 1'b0;
      if (USE_IRQ) begin
        irq_d = 1'b1;
      end else begin
        rst_cnt_d = 5'(RST_PULSE_CYCLES);
      end
    end else if (armed_q && tick) begin
      count_d = count_q - 6'h01;
    end
    if (rst_cnt_q != 5'h00) begin
      rst_cnt_d = rst_cnt_q - 5'h01;
      rst_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_q <= COUNT_RESET;
      armed_q <= ARMED_RESET;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      rst_cnt_q <= 5'h00;
      rst_q <= 1'b0;
    end else begin
      count_q <= count_d;
      armed_q <= armed_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      rst_cnt_q <= rst_cnt_d;
      rst_q <= rst_d;
    end
  end

  assign io_rdata = rdata_q;
  assign cpu_reset = rst_q;
  assign wdt_irq = irq_q;
  assign armed = armed_q;

  // pulse width helper, read by the checks below only
  logic [4:0] pw_q, pw_d;
  always_comb begin
    pw_d = 5'h00;
    if (rst_q) begin
      pw_d = pw_q + 5'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pw_q <= 5'h00;
    end else begin
      pw_q <= pw_d;
    end
  end

  // port decode, arming and disarming
  a_read_disables: assert property (@(posedge clk_sys) disable iff (!resetn)
    hit_rd |=> !armed_q)
    else $error("read did not disable");

  a_write_arms: assert property (@(posedge clk_sys) disable iff (!resetn)
    (hit_wr && !io_rd && io_wdata[5:0] != 6'h00) |=> armed_q && count_q == $past(io_wdata[5:0]))
    else $error("write did not arm");

  a_other_addr: assert property (@(posedge clk_sys) disable iff (!resetn)
    (io_addr != WDT_PORT_ADDR && !armed_q) |=> !armed_q)
    else $error("foreign address armed timer");

  a_armed_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    (armed_q && !hit_rd && !hit_wr && !expire) |=> armed_q)
    else $error("timer dropped without cause");

  a_tick_restart: assert property (@(posedge clk_sys) disable iff (!resetn)
    hit_wr |=> !tick)
    else $error("write did not restart second phase");

  // read data
  a_rdata_value: assert property (@(posedge clk_sys) disable iff (!resetn)
    hit_rd |=> io_rdata == {2'b00, $past(count_q)})
    else $error("read data not remaining count");

  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    !hit_rd |=> io_rdata == $past(io_rdata))
    else $error("read data changed without read");

  // counting down
  a_count_step: assert property (@(posedge clk_sys) disable iff (!resetn)
    (armed_q && tick && count_q > INTERVAL_MIN && !io_wr && !io_rd)
      |=> count_q == $past(count_q) - 6'h01)
    else $error("count did not step");

  a_range_held: assert property (@(posedge clk_sys) disable iff (!resetn)
    armed_q |-> count_q >= INTERVAL_MIN)
    else $error("armed with zero count");

  a_zero_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    (hit_wr && !io_rd && io_wdata[5:0] == 6'h00 && ZERO_DISABLES) |=> !armed_q)
    else $error("zero write armed timer");

  a_zero_as_one: assert property (@(posedge clk_sys) disable iff (!resetn)
    (hit_wr && !io_rd && io_wdata[5:0] == 6'h00 && !ZERO_DISABLES)
      |=> armed_q && count_q == INTERVAL_MIN)
    else $error("zero write not taken as one");

  // expiry actions
  a_expire_disarms: assert property (@(posedge clk_sys) disable iff (!resetn)
    (expire && !hit_wr) |=> !armed_q)
    else $error("still armed after expiry");

  a_expiry_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
    (expire && !hit_wr && !hit_rd && !USE_IRQ) |=> ##1 cpu_reset)
    else $error("no reset on expiry");

  a_rst_start: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(cpu_reset) |-> $past(expire, 2))
    else $error("reset pulse without expiry");

  a_pulse_width: assert property (@(posedge clk_sys) disable iff (!resetn)
    pw_q <= 5'(RST_PULSE_CYCLES))
    else $error("reset pulse too long");

  a_pulse_full: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(cpu_reset) |-> pw_q == 5'(RST_PULSE_CYCLES))
    else $error("reset pulse cut short");

  a_disarmed_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!armed_q && rst_cnt_q == 5'h00) |=> !rst_q)
    else $error("reset while disarmed");

  // interrupt flag: set on expiry, held until a port write
  a_expiry_irq: assert property (@(posedge clk_sys) disable iff (!resetn)
    (expire && !hit_wr && !hit_rd && USE_IRQ) |=> wdt_irq)
    else $error("no irq on expiry");

  a_irq_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wdt_irq && !hit_wr) |=> wdt_irq)
    else $error("irq dropped without write");

  a_irq_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    (hit_wr && !io_rd && !expire) |=> !wdt_irq)
    else $error("write did not clear irq");
endmodule
`default_nettype wire

// *** verilog/sec_tick.sv ***
// one-second tick generator, restartable
`timescale 1ns/100ps
`default_nettype none
module sec_tick #(
  parameter int PERIOD = 100000000
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic restart,
  output logic tick
);
  logic [31:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  assign tick = tick_q;
  always_comb begin
    cnt_d = cnt_q + 32'h1;
    tick_d = 1'b0;
    if (restart) begin
      cnt_d = 32'h0;
    end else if (cnt_q == 32'(PERIOD - 1)) begin
      cnt_d = 32'h0;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
endmodule
`default_nettype wire

// *** verilog/wdt_pkg.sv ***
// constants for the io port watchdog timer
package wdt_pkg;
  localparam logic [15:0] WDT_PORT_ADDR = 16'h0443;
  localparam logic [5:0] INTERVAL_MIN = 6'h01;
  localparam logic [5:0] INTERVAL_MAX = 6'h3F;
  localparam int CLK_HZ = 100000000;
  localparam int TICK_SEC = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_SEC;
  localparam logic [5:0] COUNT_RESET = 6'h00;
  localparam logic ARMED_RESET = 1'b0;
  localparam int RST_PULSE_CYCLES = 16;
endpackage
